// ===== eq_boost_params.svh
`ifndef EQ_BOOST_PARAMS_SVH
`define EQ_BOOST_PARAMS_SVH

// Register offsets within the channel page
`define EQB_OFS_PRESET13 8'h4d
`define EQB_OFS_PRESET14 8'h4e
`define EQB_OFS_PRESET15 8'h4f
`define EQB_OFS_READBACK 8'h52
`define EQB_OFS_ADAPT 8'h55

// Reset values
`define EQB_RST_PRESET13 8'ha5
`define EQB_RST_PRESET14 8'he6
`define EQB_RST_PRESET15 8'hf9
`define EQB_RST_READBACK 8'h00
`define EQB_RST_ADAPT 8'h00

// Adaptation control layout
`define EQB_ADAPT_RO_BIT 7
`define EQB_ADAPT_INIT_BIT 1
`define EQB_ADAPT_WR_MASK 8'h7f

// Answer to an unmapped read
`define EQB_UNMAPPED_DATA 8'h00

// Number of preset registers in this bank
`define EQB_NUM_PRESETS 3

`endif

// ===== eq_boost_pkg.sv
`default_nettype none

package eq_boost_pkg;

    // One register access from the serial management port front end
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    // Four 2-bit boost stage fields, stage 0 in the top bits
    typedef struct packed {
        logic [1:0] stage0;
        logic [1:0] stage1;
        logic [1:0] stage2;
        logic [1:0] stage3;
    } boost_stages_t;

    // Read answer
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } reg_rsp_t;

endpackage

`default_nettype wire

// ===== boost_preset_reg.sv
`timescale 1ns/1ps
`default_nettype none
`include "eq_boost_params.svh"

module boost_preset_reg
    import eq_boost_pkg::*;
#(
    parameter logic [7:0] OFFSET = `EQB_OFS_PRESET13,
    parameter logic [7:0] RESET_VALUE = `EQB_RST_PRESET13
) (
    input wire logic clock,
    input wire logic rstn,
    input wire reg_req_t req,
    output boost_stages_t value_r
);

    ////////////////////////////////////////////////////////////////////////
    // Preset storage, four read-write stage fields in one byte
    always_ff @(posedge clock) begin
        if (!rstn) begin
            value_r <= boost_stages_t'(RESET_VALUE);
        end else if (req.wr && req.addr == OFFSET) begin
            value_r <= boost_stages_t'(req.wdata); // see [RULE1]
        end
    end

endmodule // boost_preset_reg

`default_nettype wire

// ===== eq_boost_index_registers.sv
// Function
// [RULE1] Each preset holds four read-write 2-bit stage fields, stage 0 on top.
// [RULE2] Index 13 preset lives at 0x4D, resets to 0xA5.
// [RULE3] Index 14 preset lives at 0x4E, resets to 0xE6.
// [RULE4] Index 15 preset lives at 0x4F, resets to 0xF9.
// [RULE5] Read-only 0x52 shows boost applied to equalizer; 0x00 after reset.
// [RULE6] Adaptation control at 0x55 resets to 0x00; bit 7 read-only.
// [RULE7] Software sets adaptation control bit 1 during power-up init.
// [RULE8] Other reserved adaptation bits keep written values, no other effect.
`timescale 1ns/1ps
`default_nettype none
`include "eq_boost_params.svh"

module eq_boost_index_registers
    import eq_boost_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    input wire reg_req_t reg_req,
    input wire logic [7:0] applied_boost_value,
    output reg_rsp_t reg_rsp_r,
    output boost_stages_t boost_preset_index13,
    output boost_stages_t boost_preset_index14,
    output boost_stages_t boost_preset_index15,
    output logic [7:0] low_rate_adapt_control,
    output logic adapt_init_enable
);

    ////////////////////////////////////////////////////////////////////////
    // Address decode helper
    function automatic logic addr_hit(input logic [7:0] addr,
                                      input logic [7:0] ofs);
        addr_hit = (addr == ofs);
    endfunction

    localparam logic [`EQB_NUM_PRESETS-1:0][7:0] PRESET_OFS = {
        `EQB_OFS_PRESET15, `EQB_OFS_PRESET14, `EQB_OFS_PRESET13};
    localparam logic [`EQB_NUM_PRESETS-1:0][7:0] PRESET_RST = {
        `EQB_RST_PRESET15, `EQB_RST_PRESET14, `EQB_RST_PRESET13};

    boost_stages_t preset_r [`EQB_NUM_PRESETS];
    logic [7:0] readback_r;
    logic [7:0] adapt_r;
    logic [7:0] rdata_nxt;

    ////////////////////////////////////////////////////////////////////////
    // Preset registers, one instance per boost index
    genvar gi;
    generate
        for (gi = 0; gi < `EQB_NUM_PRESETS; gi++) begin : g_preset
            boost_preset_reg #(
                .OFFSET(PRESET_OFS[gi]), // see [RULE2] [RULE3] [RULE4]
                .RESET_VALUE(PRESET_RST[gi])
            ) u_preset (
                .clock(clock),
                .rstn(rstn),
                .req(reg_req),
                .value_r(preset_r[gi])
            );
        end
    endgenerate

    assign boost_preset_index13 = preset_r[0];
    assign boost_preset_index14 = preset_r[1];
    assign boost_preset_index15 = preset_r[2];

    ////////////////////////////////////////////////////////////////////////
    // Applied boost capture; bus writes never reach it
    always_ff @(posedge clock) begin
        if (!rstn) begin
            readback_r <= `EQB_RST_READBACK;
        end else begin
            readback_r <= applied_boost_value; // see [RULE5]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Low-rate adaptation control; bit 7 stays zero
    always_ff @(posedge clock) begin
        if (!rstn) begin
            adapt_r <= `EQB_RST_ADAPT; // see [RULE6]
        end else if (reg_req.wr && addr_hit(reg_req.addr, `EQB_OFS_ADAPT)) begin
            adapt_r <= reg_req.wdata & `EQB_ADAPT_WR_MASK; // see [RULE6] [RULE8]
        end
    end

    assign low_rate_adapt_control = adapt_r;
    // Init bit, which software sets at power-up
    assign adapt_init_enable = adapt_r[`EQB_ADAPT_INIT_BIT]; // see [RULE7]

    ////////////////////////////////////////////////////////////////////////
    // Read data select
    always_comb begin
        rdata_nxt = `EQB_UNMAPPED_DATA;
        if (addr_hit(reg_req.addr, `EQB_OFS_PRESET13)) begin
            rdata_nxt = preset_r[0];
        end else if (addr_hit(reg_req.addr, `EQB_OFS_PRESET14)) begin
            rdata_nxt = preset_r[1];
        end else if (addr_hit(reg_req.addr, `EQB_OFS_PRESET15)) begin
            rdata_nxt = preset_r[2];
        end else if (addr_hit(reg_req.addr, `EQB_OFS_READBACK)) begin
            rdata_nxt = readback_r; // see [RULE5]
        end else if (addr_hit(reg_req.addr, `EQB_OFS_ADAPT)) begin
            rdata_nxt = adapt_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registered read answer, one cycle after the request
    always_ff @(posedge clock) begin
        if (!rstn) begin
            reg_rsp_r <= '0;
        end else begin
            reg_rsp_r.valid <= reg_req.rd;
            if (reg_req.rd) begin
                reg_rsp_r.data <= rdata_nxt;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    logic wr13, wr14, wr15, wr_rb, wr_ad, rd_any;
    assign wr13 = reg_req.wr && addr_hit(reg_req.addr, `EQB_OFS_PRESET13);
    assign wr14 = reg_req.wr && addr_hit(reg_req.addr, `EQB_OFS_PRESET14);
    assign wr15 = reg_req.wr && addr_hit(reg_req.addr, `EQB_OFS_PRESET15);
    assign wr_rb = reg_req.wr && addr_hit(reg_req.addr, `EQB_OFS_READBACK);
    assign wr_ad = reg_req.wr && addr_hit(reg_req.addr, `EQB_OFS_ADAPT);
    assign rd_any = reg_req.rd;

    a_preset_reset: assert property ( // see [RULE2] [RULE3] [RULE4]
        @(posedge clock) !rstn |=>
            (boost_preset_index13 == `EQB_RST_PRESET13) &&
            (boost_preset_index14 == `EQB_RST_PRESET14) &&
            (boost_preset_index15 == `EQB_RST_PRESET15))
        else $error("Preset reset value wrong");

    a_other_reset: assert property ( // see [RULE5] [RULE6]
        @(posedge clock) !rstn |=>
            (readback_r == `EQB_RST_READBACK) &&
            (low_rate_adapt_control == `EQB_RST_ADAPT))
        else $error("Readback or adaptation reset value wrong");

    a_preset13_write: assert property ( // see [RULE2]
        @(posedge clock) disable iff (!rstn)
        wr13 |=> boost_preset_index13 == $past(reg_req.wdata))
        else $error("Index 13 write lost");

    a_preset14_stage: assert property ( // see [RULE1] [RULE3]
        @(posedge clock) disable iff (!rstn)
        wr14 |=> boost_preset_index14.stage0 == $past(reg_req.wdata[7:6]) &&
                 boost_preset_index14.stage3 == $past(reg_req.wdata[1:0]))
        else $error("Index 14 stage fields misplaced");

    a_preset15_hold: assert property ( // see [RULE4]
        @(posedge clock) disable iff (!rstn)
        !wr15 ##1 rstn |-> $stable(boost_preset_index15))
        else $error("Index 15 changed without a write");

    a_readback_value: assert property ( // see [RULE5]
        @(posedge clock) disable iff (!rstn)
        rd_any && addr_hit(reg_req.addr, `EQB_OFS_READBACK) ##1 rstn |->
            reg_rsp_r.valid &&
            reg_rsp_r.data == $past(applied_boost_value, 2))
        else $error("Readback does not follow applied boost");

    a_readback_ro: assert property ( // see [RULE5]
        @(posedge clock) disable iff (!rstn)
        wr_rb && reg_req.wdata != applied_boost_value |=>
            readback_r == $past(applied_boost_value))
        else $error("Write reached the readback register");

    a_adapt_bit7: assert property ( // see [RULE6]
        @(posedge clock) disable iff (!rstn)
        wr_ad |=> !low_rate_adapt_control[`EQB_ADAPT_RO_BIT] &&
                  low_rate_adapt_control[6:0] == $past(reg_req.wdata[6:0]))
        else $error("Adaptation write wrong or bit 7 set");

    a_adapt_hold: assert property ( // see [RULE8]
        @(posedge clock) disable iff (!rstn)
        !wr_ad ##1 rstn |-> $stable(low_rate_adapt_control))
        else $error("Adaptation control changed without a write");

    a_init_bit: assert property ( // see [RULE7]
        @(posedge clock) disable iff (!rstn)
        adapt_init_enable == low_rate_adapt_control[`EQB_ADAPT_INIT_BIT])
        else $error("Init bit does not follow adaptation control");

    a_unmapped_read: assert property (
        @(posedge clock) disable iff (!rstn)
        rd_any && !addr_hit(reg_req.addr, `EQB_OFS_PRESET13) &&
        !addr_hit(reg_req.addr, `EQB_OFS_PRESET14) &&
        !addr_hit(reg_req.addr, `EQB_OFS_PRESET15) &&
        !addr_hit(reg_req.addr, `EQB_OFS_READBACK) &&
        !addr_hit(reg_req.addr, `EQB_OFS_ADAPT) |=>
            reg_rsp_r.data == `EQB_UNMAPPED_DATA)
        else $error("Unmapped read not zero");

    c_preset_write: cover property (
        @(posedge clock) disable iff (!rstn) wr13 ##1 wr14 ##1 wr15);

    c_readback_read: cover property (
        @(posedge clock) disable iff (!rstn)
        rd_any && addr_hit(reg_req.addr, `EQB_OFS_READBACK) ##1
        reg_rsp_r.data != `EQB_RST_READBACK);

    c_init_set: cover property (
        @(posedge clock) disable iff (!rstn) $rose(adapt_init_enable));

    c_write_then_read: cover property (
        @(posedge clock) disable iff (!rstn)
        wr_ad ##1 rd_any && addr_hit(reg_req.addr, `EQB_OFS_ADAPT));

endmodule // eq_boost_index_registers

`default_nettype wire

// ===== tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb
    import eq_boost_pkg::*;
;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    reg_req_t reg_req = '0;
    logic [7:0] applied_boost_value = 8'h00;
    reg_rsp_t reg_rsp_r;
    boost_stages_t boost_preset_index13;
    boost_stages_t boost_preset_index14;
    boost_stages_t boost_preset_index15;
    logic [7:0] low_rate_adapt_control;
    logic adapt_init_enable;
    int error_cnt = 0;
    int check_count = 0;
    int cycle_cnt = 0;
    logic [7:0] mdl [3];
    logic [7:0] mdl_adapt;
    logic [7:0] mdl_applied = 8'h00;
    logic [7:0] addrs [6] = '{8'h4d, 8'h4e, 8'h4f, 8'h52, 8'h55, 8'h50};
    logic [7:0] adapt_pat [4] = '{8'hff, 8'h80, 8'h02, 8'hfd};

    eq_boost_index_registers dut (
        .clock(clock),
        .rstn(rstn),
        .reg_req(reg_req),
        .applied_boost_value(applied_boost_value),
        .reg_rsp_r(reg_rsp_r),
        .boost_preset_index13(boost_preset_index13),
        .boost_preset_index14(boost_preset_index14),
        .boost_preset_index15(boost_preset_index15),
        .low_rate_adapt_control(low_rate_adapt_control),
        .adapt_init_enable(adapt_init_enable)
    );

    ////////////////////////////////////////////////////////////////////////
    // Clock and hang guard
    always #4 clock = ~clock;

    always @(posedge clock) begin
        cycle_cnt <= cycle_cnt + 1;
        if (cycle_cnt == 20000) begin
            error_cnt = error_cnt + 1;
            close_out();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Compare, model and bus tasks
    task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                         input string what);
        check_count = check_count + 1;
        if (seen !== exp) begin
            error_cnt = error_cnt + 1;
            $display("mismatch at %0t: %s saw %h want %h", $time, what,
                     seen, exp);
        end
    endtask

    task automatic model_reset();
        mdl[0] = 8'ha5;
        mdl[1] = 8'he6;
        mdl[2] = 8'hf9;
        mdl_adapt = 8'h00;
    endtask

    function automatic logic [7:0] exp_read(input logic [7:0] a);
        case (a)
            8'h4d: return mdl[0];
            8'h4e: return mdl[1];
            8'h4f: return mdl[2];
            8'h52: return mdl_applied;
            8'h55: return mdl_adapt;
            default: return 8'h00;
        endcase
    endfunction

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clock);
        reg_req <= '0;
        // Read-only readback ignores writes, bit 7 of adaptation is fixed
        case (a)
            8'h4d: mdl[0] = d;
            8'h4e: mdl[1] = d;
            8'h4f: mdl[2] = d;
            8'h55: mdl_adapt = d & 8'h7f;
            default: ;
        endcase
        #1;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge clock);
        reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'($urandom)};
        @(posedge clock);
        reg_req <= '0;
        #1;
        check({7'h0, reg_rsp_r.valid}, 8'h01, "valid");
        check(reg_rsp_r.data, exp_read(a), "read");
        @(posedge clock);
        #1;
        check({7'h0, reg_rsp_r.valid}, 8'h00, "valid drop");
    endtask

    task automatic check_ports();
        check(boost_preset_index13, mdl[0], "p13");
        check(boost_preset_index14, mdl[1], "p14");
        check(boost_preset_index15, mdl[2], "p15");
        check({6'h0, boost_preset_index13.stage0}, {6'h0, mdl[0][7:6]},
              "stage0");
        check({6'h0, boost_preset_index14.stage2}, {6'h0, mdl[1][3:2]},
              "stage2");
        check(low_rate_adapt_control, mdl_adapt, "adapt");
        check({7'h0, adapt_init_enable}, {7'h0, mdl_adapt[1]},
              "init");
    endtask

    task automatic read_all();
        foreach (addrs[i]) begin
            rd(addrs[i]);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        logic [7:0] a;
        logic [7:0] d;
        void'($urandom(32'h9b0ec5be));
        model_reset();
        repeat (2) @(posedge clock);
        rstn <= 1'b1;
        #1;
        check_ports();
        read_all();
        $display("test reset_values done");
        // Random writes, unmapped and read-only places among them
        for (int i = 0; i < 42; i++) begin
            a = (i % 7 == 6) ? 8'($urandom) : addrs[i % 6];
            d = 8'($urandom);
            wr(a, d);
            check_ports();
            rd(a);
        end
        $display("test random_writes done");
        // Readback follows the equalizer and ignores writes
        for (int i = 0; i < 8; i++) begin
            d = 8'($urandom);
            @(posedge clock);
            applied_boost_value <= d;
            mdl_applied = d;
            repeat (2) @(posedge clock);
            rd(8'h52);
            wr(8'h52, ~d);
            rd(8'h52);
        end
        $display("test readback done");
        // Adaptation control with the init bit and the fixed bit 7
        foreach (adapt_pat[i]) begin
            wr(8'h55, adapt_pat[i]);
            check_ports();
            rd(8'h55);
        end
        $display("test adapt_control done");
        // Reset in mid-run restores the defaults
        @(posedge clock);
        rstn <= 1'b0;
        @(posedge clock);
        rstn <= 1'b1;
        model_reset();
        #1;
        check_ports();
        read_all();
        $display("test mid_reset done");
        close_out();
    end

endmodule // tb

`default_nettype wire
